// file: bench/qss_sync_select_tb_top.sv
`timescale 1ns/100ps
module qss_sync_select_tb_top;
	import qss_pkg::*;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	qss_addr_t regAddr = 8'h00;
	qss_word_t regWrData = 16'h0000;
	logic regWrEn = 1'b0;
	logic regRdEn = 1'b0;
	qss_word_t regRdData;
	logic externalSyncInput = 1'b0;
	logic outputStrobeInput = 1'b0;
	qss_word_t act[NUM_GROUPS];
	logic [TEST_SEL_W-1:0] testSel;
	logic extRef;
	logic fuseSlp;
	qss_word_t expAct[NUM_GROUPS];
	qss_word_t val;
	logic [5:0] codes[14] = '{6'h0E, 6'h0F, 6'h10, 6'h16, 6'h17, 6'h18, 6'h1E, 6'h1F,
		6'h20, 6'h26, 6'h27, 6'h28, 6'h30, 6'h05};
	int numErrors = 0;
	int comparisons = 0;

	always #20 core_clk = ~core_clk;

	qss_sync_select qss_sync_select_inst (
		.core_clk(core_clk),
		.rstn(rstn),
		.regAddr(regAddr),
		.regWrData(regWrData),
		.regWrEn(regWrEn),
		.regRdEn(regRdEn),
		.regRdData(regRdData),
		.externalSyncInput(externalSyncInput),
		.outputStrobeInput(outputStrobeInput),
		.activeOffsetPair1(act[0]),
		.activeOffsetPair2(act[1]),
		.activeGainPhasePair1(act[2]),
		.activeGainPhasePair2(act[3]),
		.transmitEnableTestSelect(testSel),
		.externalReferenceEnable(extRef),
		.fuseSleep(fuseSlp)
	);

	task automatic chk(input qss_word_t got, input qss_word_t exp);
		comparisons++;
		if (got !== exp) begin
			numErrors++;
			$display("BAD at %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input qss_addr_t a, input qss_word_t d);
		@(posedge core_clk);
		regWrEn <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge core_clk);
		regWrEn <= 1'b0;
		#1;
	endtask : wr

	task automatic rdChk(input qss_addr_t a, input qss_word_t exp);
		@(posedge core_clk);
		regRdEn <= 1'b1;
		regAddr <= a;
		@(posedge core_clk);
		regRdEn <= 1'b0;
		#1;
		chk(regRdData, exp);
	endtask : rdChk

	task automatic chkAll();
		for (int g = 0; g < NUM_GROUPS; g++) begin
			chk(act[g], expAct[g]);
		end
	endtask : chkAll

	// Pins stay high and low long enough for the two-flop synchroniser to see them.
	task automatic fire(input int src);
		if (src == SRC_SOFT) begin
			wr(ADDR_SW_SYNC, 16'h0002);
			wr(ADDR_SW_SYNC, 16'h0000);
		end else begin
			@(posedge core_clk);
			if (src == SRC_EXT) externalSyncInput <= 1'b1;
			else outputStrobeInput <= 1'b1;
			repeat (3) @(posedge core_clk);
			externalSyncInput <= 1'b0;
			outputStrobeInput <= 1'b0;
			repeat (4) @(posedge core_clk);
			#1;
		end
	endtask : fire

	task automatic doReset();
		@(posedge core_clk);
		rstn <= 1'b0;
		repeat (2) @(posedge core_clk);
		rstn <= 1'b1;
		for (int g = 0; g < NUM_GROUPS; g++) expAct[g] = 16'h0000;
	endtask : doReset

	task automatic results();
		$display("Comparisons %0d, errors %0d", comparisons, numErrors);
		if (numErrors == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : results

	initial begin
		repeat (6000) @(posedge core_clk);
		numErrors++;
		results();
	end

	initial begin
		for (int g = 0; g < NUM_GROUPS; g++) expAct[g] = 16'h0000;
		repeat (2) @(posedge core_clk);
		rstn <= 1'b1;
		#1;
		chkAll();
		rdChk(ADDR_SYNC_SEL, 16'h1111);
		rdChk(ADDR_RSVD_A, 16'h0000);
		rdChk(ADDR_RSVD_B, 16'h0000);
		rdChk(ADDR_REF_TEST, 16'h0000);
		chk(qss_word_t'(testSel), 16'h0000);
		wr(8'h30, 16'hBEEF);
		rdChk(8'h30, 16'h0000);
		// Default selection: every shadow write lands in its active value at once.
		for (int g = 0; g < NUM_GROUPS; g++) begin
			val = qss_word_t'(16'h5A00 + g);
			wr(qss_addr_t'(ADDR_SHADOW_BASE + g), val);
			expAct[g] = val;
			chkAll();
		end
		// One source at a time in each field; a shadow write or one other source must not move it.
		for (int g = 0; g < NUM_GROUPS; g++) begin
			for (int s = SRC_STROBE; s <= SRC_SOFT; s++) begin
				val = qss_word_t'(16'hA000 + 16 * g + s);
				wr(ADDR_SYNC_SEL, qss_word_t'(16'h0001) << (12 - 4 * g + s));
				wr(qss_addr_t'(ADDR_SHADOW_BASE + g), val);
				chkAll();
				fire((s == SRC_SOFT) ? SRC_EXT : s + 1);
				chkAll();
				fire(s);
				expAct[g] = val;
				chkAll();
				rdChk(qss_addr_t'(ADDR_ACTIVE_BASE + g), val);
			end
		end
		// Several fields share one source and update together.
		wr(ADDR_SYNC_SEL, 16'h4444);
		for (int g = 0; g < NUM_GROUPS; g++) begin
			wr(qss_addr_t'(ADDR_SHADOW_BASE + g), qss_word_t'(16'hC300 + g));
			rdChk(qss_addr_t'(ADDR_SHADOW_BASE + g), qss_word_t'(16'hC300 + g));
		end
		chkAll();
		fire(SRC_EXT);
		for (int g = 0; g < NUM_GROUPS; g++) expAct[g] = qss_word_t'(16'hC300 + g);
		chkAll();
		wr(ADDR_SYNC_SEL, 16'hFFFF);
		wr(ADDR_SHADOW_BASE, 16'h7E7E);
		expAct[0] = 16'h7E7E;
		chkAll();
		wr(ADDR_ACTIVE_BASE, 16'hDEAD);
		rdChk(ADDR_ACTIVE_BASE, 16'h7E7E);
		foreach (codes[i]) begin
			wr(ADDR_REF_TEST, {10'h000, codes[i]});
			chk(qss_word_t'(testSel), {10'h000, codes[i]});
		end
		wr(ADDR_REF_TEST, 16'hFFFF);
		rdChk(ADDR_REF_TEST, 16'h883F);
		chk({14'h0000, extRef, fuseSlp}, 16'h0003);
		doReset();
		#1;
		chkAll();
		rdChk(ADDR_SYNC_SEL, 16'h1111);
		chk({8'h00, extRef, fuseSlp, testSel}, 16'h0000);
		results();
	end
endmodule : qss_sync_select_tb_top

// file: rtl/qss_pkg.sv
package qss_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam int NUM_GROUPS = 4;
	localparam int SEL_W = 4;
	localparam int TEST_SEL_W = 6;

	typedef logic [DATA_W-1:0] qss_word_t;
	typedef logic [ADDR_W-1:0] qss_addr_t;

	// Register offsets.
	localparam qss_addr_t ADDR_REF_TEST = 8'h1B;
	localparam qss_addr_t ADDR_RSVD_A = 8'h1C;
	localparam qss_addr_t ADDR_RSVD_B = 8'h1D;
	localparam qss_addr_t ADDR_SYNC_SEL = 8'h1E;
	localparam qss_addr_t ADDR_SW_SYNC = 8'h1F;
	localparam qss_addr_t ADDR_SHADOW_BASE = 8'h40;
	localparam qss_addr_t ADDR_ACTIVE_BASE = 8'h48;

	// Values after reset.
	localparam qss_word_t SYNC_SEL_RESET = 16'h1111;
	localparam qss_word_t REF_TEST_RESET = 16'h0000;
	localparam qss_word_t RSVD_RESET = 16'h0000;
	localparam qss_word_t SHADOW_RESET = 16'h0000;
	localparam qss_word_t ACTIVE_RESET = 16'h0000;
	localparam qss_word_t RDATA_IDLE = 16'h0000;
	localparam logic SW_SYNC_RESET = 1'b0;
	localparam logic PIN_SYNC_RESET = 1'b0;

	// Field positions.
	localparam int OFS_PAIR1_LSB = 12;
	localparam int OFS_PAIR2_LSB = 8;
	localparam int GP_PAIR1_LSB = 4;
	localparam int GP_PAIR2_LSB = 0;
	localparam int REF_EXT_BIT = 15;
	localparam int FUSE_SLEEP_BIT = 11;
	localparam int TEST_SEL_LSB = 0;
	localparam int SW_SYNC_BIT = 1;
	localparam qss_word_t REF_TEST_MASK = 16'h883F;

	// Source positions inside each 4-bit select field.
	localparam int SRC_SOFT = 3;
	localparam int SRC_EXT = 2;
	localparam int SRC_STROBE = 1;
	localparam int SRC_AUTO = 0;
endpackage : qss_pkg

// file: rtl/qss_shadow_group.sv
`timescale 1ns/100ps
module qss_shadow_group (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic shadowWrite,
	input wire qss_pkg::qss_word_t writeData,
	input wire logic syncEvent,
	output qss_pkg::qss_word_t shadowValue,
	output qss_pkg::qss_word_t activeValue
);
	import qss_pkg::*;

	qss_word_t shadowFf;
	qss_word_t activeFf;
	qss_word_t nxt_shadowFf;
	qss_word_t nxt_activeFf;

	// A write coinciding with a sync lands directly in the active value,
	// so the whole word moves at once and never half old, half new.
	always_comb begin
		nxt_shadowFf = shadowWrite ? writeData : shadowFf;
		nxt_activeFf = syncEvent ? nxt_shadowFf : activeFf;
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			shadowFf <= SHADOW_RESET;
			activeFf <= ACTIVE_RESET;
		end else begin
			shadowFf <= nxt_shadowFf;
			activeFf <= nxt_activeFf;
		end
	end

	assign shadowValue = shadowFf;
	assign activeValue = activeFf;
endmodule : qss_shadow_group

// file: rtl/qss_sync_select.sv
// Local design decision: the strobed register port.
`timescale 1ns/100ps
module qss_sync_select (
	input wire logic core_clk,
	input wire logic rstn,
	input wire qss_pkg::qss_addr_t regAddr,
	input wire qss_pkg::qss_word_t regWrData,
	input wire logic regWrEn,
	input wire logic regRdEn,
	output qss_pkg::qss_word_t regRdData,
	input wire logic externalSyncInput,
	input wire logic outputStrobeInput,
	output qss_pkg::qss_word_t activeOffsetPair1,
	output qss_pkg::qss_word_t activeOffsetPair2,
	output qss_pkg::qss_word_t activeGainPhasePair1,
	output qss_pkg::qss_word_t activeGainPhasePair2,
	output logic [qss_pkg::TEST_SEL_W-1:0] transmitEnableTestSelect,
	output logic externalReferenceEnable,
	output logic fuseSleep
);
	import qss_pkg::*;

	// Register state.
	qss_word_t selectFf;
	qss_word_t refTestFf;
	qss_word_t rsvdAFf;
	qss_word_t rsvdBFf;
	logic swSyncFf;
	qss_word_t nxt_selectFf;
	qss_word_t nxt_refTestFf;
	qss_word_t nxt_rsvdAFf;
	qss_word_t nxt_rsvdBFf;
	logic nxt_swSyncFf;

	// Edge detection and pin synchronisers.
	logic swPrevFf;
	logic extMetaFf;
	logic extSyncFf;
	logic extPrevFf;
	logic strobeMetaFf;
	logic strobeSyncFf;
	logic strobePrevFf;
	logic nxt_swPrevFf;
	logic nxt_extMetaFf;
	logic nxt_extSyncFf;
	logic nxt_extPrevFf;
	logic nxt_strobeMetaFf;
	logic nxt_strobeSyncFf;
	logic nxt_strobePrevFf;

	// Read data.
	qss_word_t rdDataFf;
	qss_word_t nxt_rdDataFf;

	logic swRise;
	logic extRise;
	logic strobeRise;
	logic [SEL_W-1:0] offsetPair1SyncEnables;
	logic [SEL_W-1:0] offsetPair2SyncEnables;
	logic [SEL_W-1:0] gainphasePair1SyncEnables;
	logic [SEL_W-1:0] gainphasePair2SyncEnables;
	logic [SEL_W-1:0] selFields [NUM_GROUPS];
	logic [NUM_GROUPS-1:0] shadowWr;
	logic [NUM_GROUPS-1:0] groupEvent;
	qss_word_t shadowArr [NUM_GROUPS];
	qss_word_t activeArr [NUM_GROUPS];

	assign offsetPair1SyncEnables = selectFf[OFS_PAIR1_LSB +: SEL_W];
	assign offsetPair2SyncEnables = selectFf[OFS_PAIR2_LSB +: SEL_W];
	assign gainphasePair1SyncEnables = selectFf[GP_PAIR1_LSB +: SEL_W];
	assign gainphasePair2SyncEnables = selectFf[GP_PAIR2_LSB +: SEL_W];
	assign selFields[0] = offsetPair1SyncEnables;
	assign selFields[1] = offsetPair2SyncEnables;
	assign selFields[2] = gainphasePair1SyncEnables;
	assign selFields[3] = gainphasePair2SyncEnables;

	// Only a rising edge syncs, so the bit may be left high until cleared.
	assign swRise = swSyncFf & ~swPrevFf;
	assign extRise = extSyncFf & ~extPrevFf;
	assign strobeRise = strobeSyncFf & ~strobePrevFf;

	always_comb begin
		nxt_selectFf = selectFf;
		nxt_refTestFf = refTestFf;
		nxt_rsvdAFf = rsvdAFf;
		nxt_rsvdBFf = rsvdBFf;
		nxt_swSyncFf = swSyncFf;
		if (regWrEn) begin
			case (regAddr)
				ADDR_SYNC_SEL: begin
					nxt_selectFf = regWrData;
				end
				ADDR_REF_TEST: begin
					nxt_refTestFf = regWrData & REF_TEST_MASK;
				end
				ADDR_RSVD_A: begin
					nxt_rsvdAFf = regWrData;
				end
				ADDR_RSVD_B: begin
					nxt_rsvdBFf = regWrData;
				end
				ADDR_SW_SYNC: begin
					nxt_swSyncFf = regWrData[SW_SYNC_BIT];
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			selectFf <= SYNC_SEL_RESET;
			refTestFf <= REF_TEST_RESET;
			rsvdAFf <= RSVD_RESET;
			rsvdBFf <= RSVD_RESET;
			swSyncFf <= SW_SYNC_RESET;
		end else begin
			selectFf <= nxt_selectFf;
			refTestFf <= nxt_refTestFf;
			rsvdAFf <= nxt_rsvdAFf;
			rsvdBFf <= nxt_rsvdBFf;
			swSyncFf <= nxt_swSyncFf;
		end
	end

	// Pins pass two flip-flops; the edge detector compares the second with its one-cycle delayed copy.
	always_comb begin
		nxt_swPrevFf = swSyncFf;
		nxt_extMetaFf = externalSyncInput;
		nxt_extSyncFf = extMetaFf;
		nxt_extPrevFf = extSyncFf;
		nxt_strobeMetaFf = outputStrobeInput;
		nxt_strobeSyncFf = strobeMetaFf;
		nxt_strobePrevFf = strobeSyncFf;
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			swPrevFf <= SW_SYNC_RESET;
			extMetaFf <= PIN_SYNC_RESET;
			extSyncFf <= PIN_SYNC_RESET;
			extPrevFf <= PIN_SYNC_RESET;
			strobeMetaFf <= PIN_SYNC_RESET;
			strobeSyncFf <= PIN_SYNC_RESET;
			strobePrevFf <= PIN_SYNC_RESET;
		end else begin
			swPrevFf <= nxt_swPrevFf;
			extMetaFf <= nxt_extMetaFf;
			extSyncFf <= nxt_extSyncFf;
			extPrevFf <= nxt_extPrevFf;
			strobeMetaFf <= nxt_strobeMetaFf;
			strobeSyncFf <= nxt_strobeSyncFf;
			strobePrevFf <= nxt_strobePrevFf;
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_GROUPS; g++) begin : gen_group
			assign shadowWr[g] = regWrEn && (regAddr == ADDR_SHADOW_BASE + ADDR_W'(g));
			// Any enabled source, alone or together with others, fires the group.
			assign groupEvent[g] = |(selFields[g] & {swRise, extRise, strobeRise,
				shadowWr[g]});

			qss_shadow_group qss_shadow_group_inst (
				.core_clk(core_clk),
				.rstn(rstn),
				.shadowWrite(shadowWr[g]),
				.writeData(regWrData),
				.syncEvent(groupEvent[g]),
				.shadowValue(shadowArr[g]),
				.activeValue(activeArr[g])
			);

			active_holds_a: assert property (@(posedge core_clk) disable iff (!rstn)
				!groupEvent[g] |=> $stable(activeArr[g]))
				else $error("active value moved without a sync event");

			auto_sync_copy_a: assert property (@(posedge core_clk) disable iff (!rstn)
				shadowWr[g] && selFields[g][SRC_AUTO] |=> activeArr[g] == $past(regWrData))
				else $error("auto sync did not load the written word");
		end
	endgenerate

	// Read data stands only in the cycle after the read strobe.
	always_comb begin
		nxt_rdDataFf = RDATA_IDLE;
		if (regRdEn) begin
			case (regAddr)
				ADDR_SYNC_SEL: begin
					nxt_rdDataFf = selectFf;
				end
				ADDR_REF_TEST: begin
					nxt_rdDataFf = refTestFf;
				end
				ADDR_RSVD_A: begin
					nxt_rdDataFf = rsvdAFf;
				end
				ADDR_RSVD_B: begin
					nxt_rdDataFf = rsvdBFf;
				end
				ADDR_SW_SYNC: begin
					nxt_rdDataFf[SW_SYNC_BIT] = swSyncFf;
				end
				default: begin
					for (int i = 0; i < NUM_GROUPS; i++) begin
						if (regAddr == ADDR_SHADOW_BASE + ADDR_W'(i)) begin
							nxt_rdDataFf = shadowArr[i];
						end
						if (regAddr == ADDR_ACTIVE_BASE + ADDR_W'(i)) begin
							nxt_rdDataFf = activeArr[i];
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rdDataFf <= RDATA_IDLE;
		end else begin
			rdDataFf <= nxt_rdDataFf;
		end
	end

	assign regRdData = rdDataFf;
	assign activeOffsetPair1 = activeArr[0];
	assign activeOffsetPair2 = activeArr[1];
	assign activeGainPhasePair1 = activeArr[2];
	assign activeGainPhasePair2 = activeArr[3];
	assign transmitEnableTestSelect = refTestFf[TEST_SEL_LSB +: TEST_SEL_W];
	assign externalReferenceEnable = refTestFf[REF_EXT_BIT];
	assign fuseSleep = refTestFf[FUSE_SLEEP_BIT];

	soft_sync_pair1_a: assert property (@(posedge core_clk) disable iff (!rstn)
		$rose(swSyncFf) && selectFf[OFS_PAIR1_LSB + SRC_SOFT] && !shadowWr[0]
		|=> activeArr[0] == $past(shadowArr[0]))
		else $error("software sync did not update offset pair1");

	ext_sync_pair2_a: assert property (@(posedge core_clk) disable iff (!rstn)
		extSyncFf && !extPrevFf && selectFf[OFS_PAIR2_LSB + SRC_EXT] && !shadowWr[1]
		|=> activeArr[1] == $past(shadowArr[1]))
		else $error("external sync did not update offset pair2");

	strobe_gp_pair1_a: assert property (@(posedge core_clk) disable iff (!rstn)
		strobeSyncFf && !strobePrevFf && selectFf[GP_PAIR1_LSB + SRC_STROBE]
		&& !shadowWr[2] |=> activeArr[2] == $past(shadowArr[2]))
		else $error("output strobe did not update gain/phase pair1");

	no_auto_pair2_a: assert property (@(posedge core_clk) disable iff (!rstn)
		shadowWr[3] && !selectFf[GP_PAIR2_LSB + SRC_AUTO] && !swRise && !extRise
		&& !strobeRise |=> $stable(activeArr[3]))
		else $error("gain/phase pair2 moved with auto sync off");

	any_source_a: assert property (@(posedge core_clk) disable iff (!rstn)
		((swRise && offsetPair1SyncEnables[SRC_SOFT])
		|| (extRise && offsetPair1SyncEnables[SRC_EXT])
		|| (strobeRise && offsetPair1SyncEnables[SRC_STROBE])) && !shadowWr[0]
		|=> activeArr[0] == $past(shadowArr[0]))
		else $error("an enabled source failed to update offset pair1");

	select_reset_a: assert property (@(posedge core_clk) disable iff (!rstn)
		$rose(rstn) |-> selectFf == SYNC_SEL_RESET)
		else $error("sync select not at reset value");

	test_select_a: assert property (@(posedge core_clk) disable iff (!rstn)
		regWrEn && regAddr == ADDR_REF_TEST
		|=> transmitEnableTestSelect == $past(regWrData[TEST_SEL_W-1:0]))
		else $error("test node selector not loaded");

	reserved_reset_a: assert property (@(posedge core_clk) disable iff (!rstn)
		$rose(rstn) |-> rsvdAFf == RSVD_RESET && rsvdBFf == RSVD_RESET)
		else $error("reserved registers not cleared by reset");

	sel_write_a: assert property (@(posedge core_clk) disable iff (!rstn)
		regWrEn && regAddr == ADDR_SYNC_SEL |=> selectFf == $past(regWrData))
		else $error("sync select write not stored");

	strobe_ofs_pair2_a: assert property (@(posedge core_clk) disable iff (!rstn)
		strobeRise && offsetPair2SyncEnables[SRC_STROBE] && !shadowWr[1]
		|=> activeArr[1] == $past(shadowArr[1]))
		else $error("output strobe did not update offset pair2");

	ext_gp_pair2_a: assert property (@(posedge core_clk) disable iff (!rstn)
		extRise && gainphasePair2SyncEnables[SRC_EXT] && !shadowWr[3]
		|=> activeArr[3] == $past(shadowArr[3]))
		else $error("external sync did not update gain/phase pair2");

	reserved_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
		!(regWrEn && (regAddr == ADDR_RSVD_A || regAddr == ADDR_RSVD_B))
		|=> $stable(rsvdAFf) && $stable(rsvdBFf))
		else $error("reserved register moved without a write");
endmodule : qss_sync_select
